// [rtl/sie_eval.sv]
// Safety input evaluator: classifies terminals, runs OFF/ON/ERROR.
// Assumes comparator outputs per terminal and an Avalon-MM master.
`timescale 1ns/100ps
module sie_eval
    import sie_pkg::*;
#(
    parameter int N_TERM = MAX_TERM,
    parameter int CYC_PER_MS = MS_CYC,
    parameter int SLOT_P = SLOT_CYC,
    parameter int WIN_P = WIN_CYC,
    parameter int TP_P = TP_CYC
) (
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Avalon-MM slave
    input logic [7:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Terminal comparators
    input logic [N_TERM-1:0] term_above_hi,
    input logic [N_TERM-1:0] term_above_lo,
    // Threshold settings to front end
    output logic [N_TERM*8-1:0] thr_hi_code,
    output logic [N_TERM*8-1:0] thr_lo_code,
    output logic [N_TERM-1:0] thr_volt_mode,
    // Coded pulse drive
    output logic [3:0] pulse_drive,
    output logic [3:0] pulse_drive_n,
    // Function outputs
    output logic func_on,
    output logic func_err,
    // Terminal LEDs
    output logic [N_TERM-1:0] led_red,
    output logic [N_TERM-1:0] led_green,
    output logic [N_TERM-1:0] led_orange
);
    if (N_TERM < 1 || N_TERM > MAX_TERM) begin : g_bad_n
        $error("sie_eval: N_TERM out of range");
    end
    // Tested-high gaps must be shorter than a pulse slot
    if (TP_P < 1 || SLOT_P <= TP_P + 8 || WIN_P < 8 * SLOT_P ||
        WIN_P > 65535 || CYC_PER_MS < 2 || CYC_PER_MS > 65535) begin : g_bad_t
        $error("sie_eval: timing parameters out of range");
    end

    localparam logic [15:0] WIN_L = 16'(WIN_P);
    localparam logic [15:0] TP_L = 16'(TP_P);
    localparam logic [15:0] MS_L = 16'(CYC_PER_MS - 1);

    typedef struct packed {
        logic [N_TERM-1:0][2:0] shi;
        logic [N_TERM-1:0][2:0] slo;
        logic [N_TERM-1:0] lvl;
        logic [N_TERM-1:0][15:0] age_on;
        logic [N_TERM-1:0][15:0] age_off;
        logic [N_TERM-1:0][15:0] age_err;
        logic [N_TERM-1:0][15:0] lowc;
        logic [4:0][3:0] expd;
        logic [15:0] settle;
        sie_fsm_t st;
        logic armed;
        logic [15:0] pre;
        logic tick;
        logic [15:0] mix_ms;
        logic [7:0] blink_ms;
        logic blink;
        logic err_en;
        logic estop;
        logic skew_en;
        logic [3:0] cnt;
        logic [15:0] skew_lim;
        logic [7:0] thr_hi;
        logic [7:0] thr_lo;
        logic [N_TERM-1:0] special;
        logic [N_TERM-1:0][7:0] ovr_hi;
        logic [N_TERM-1:0][7:0] ovr_lo;
        logic [N_TERM-1:0][3:0] sh_on;
        logic [N_TERM-1:0][3:0] sh_off;
        logic wreq;
        logic [31:0] rdata;
        logic on_o;
        logic err_o;
        logic [N_TERM-1:0] led_r;
        logic [N_TERM-1:0] led_g;
        logic [N_TERM-1:0] led_o;
        logic [N_TERM-1:0][7:0] thh;
        logic [N_TERM-1:0][7:0] thl;
        logic [N_TERM-1:0] vmode;
        logic [3:0] pd;
        logic [3:0] pdn;
    } sie_st_t;

    sie_st_t q, d;
    sie_pulse_if u_pif();

    sie_pulse_gen #(
        .SLOT(SLOT_P)
    ) u_gen (
        .sys_clk(sys_clk),
        .rst(rst),
        .pif(u_pif)
    );

    function automatic logic mism(input logic [3:0] c, input logic l,
                                  input logic [3:0] e, input logic [3:0] s,
                                  input logic tpo);
        logic [3:0] k;
        logic m;
        k = 4'h0;
        m = 1'b1;
        if (c == SH_STEADY_HIGH) begin
            m = !l;
        end else if (c == SH_TESTED_HIGH) begin
            m = tpo;
        end else if (c == SH_STEADY_LOW) begin
            m = l;
        end else if (c >= SH_PULSE_A && c < SH_INV_A) begin
            // Level differs from the expected bit in a stable slot
            k = c - SH_PULSE_A;
            m = s[k[1:0]] && (l != e[k[1:0]]);
        end else if (c >= SH_INV_A && c <= SH_INV_D) begin
            k = c - SH_INV_A;
            m = s[k[1:0]] && (l == e[k[1:0]]);
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] w,
                                          input logic [3:0] be);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (o & ~bm) | (w & bm);
    endfunction

    // Per-terminal classification
    logic [N_TERM-1:0] used, mis_on, mis_off, ton, toff, terr;
    logic [3:0] stab;
    logic valid, all_on, all_off, any_err, mixed, act, skew_over;
    logic [15:0] lim;

    // Transition cycles of a pulse are skipped, not judged
    assign stab = ~(q.expd[4] ^ q.expd[3]);
    assign valid = (q.settle == WIN_L);

    for (genvar i = 0; i < N_TERM; i++) begin : g_term
        assign used[i] = (4'(i) < q.cnt);
        assign mis_on[i] = mism(q.sh_on[i], q.lvl[i], q.expd[4], stab,
                                q.lowc[i] > TP_L);
        assign mis_off[i] = mism(q.sh_off[i], q.lvl[i], q.expd[4], stab,
                                 q.lowc[i] > TP_L);
        assign ton[i] = used[i] && (q.age_on[i] >= WIN_L);
        assign toff[i] = used[i] && !ton[i] && (q.age_off[i] >= WIN_L);
        // Neither shape for a full window
        // Grace of one window lets a clean shape change finish
        assign terr[i] = valid && used[i] && !ton[i] && !toff[i] &&
                         (q.age_err[i] >= WIN_L);
    end

    assign all_on = (ton == used);
    assign all_off = (toff == used);
    assign any_err = |terr;
    assign mixed = valid && !any_err && (|ton) && (|toff);
    assign lim = q.estop ? ESTOP_SKEW_MS : q.skew_lim;
    assign act = q.estop || q.skew_en;
    assign skew_over = act && mixed && (q.mix_ms > lim);

    always_comb begin
        logic [31:0] rd;
        logic [31:0] wv;
        logic [2:0] ix;
        rd = 32'h0000_0000;
        wv = 32'h0000_0000;
        ix = avs_address[4:2];
        d = q;

        for (int i = 0; i < N_TERM; i++) begin
            d.shi[i] = {q.shi[i][1:0], term_above_hi[i]};
            d.slo[i] = {q.slo[i][1:0], term_above_lo[i]};
            if (q.shi[i][2] == q.shi[i][1] && q.shi[i][2]) begin
                d.lvl[i] = 1'b1;
            end else if (q.slo[i][2] == q.slo[i][1] && !q.slo[i][2]) begin
                d.lvl[i] = 1'b0;
            end
            d.lowc[i] = q.lvl[i] ? 16'h0000 :
                        (q.lowc[i] == 16'hFFFF ? q.lowc[i] :
                         q.lowc[i] + 16'h0001);
            d.age_on[i] = mis_on[i] ? 16'h0000 :
                          (q.age_on[i] >= WIN_L ? WIN_L :
                           q.age_on[i] + 16'h0001);
            d.age_off[i] = mis_off[i] ? 16'h0000 :
                           (q.age_off[i] >= WIN_L ? WIN_L :
                            q.age_off[i] + 16'h0001);
            d.age_err[i] = (!valid || !used[i] || ton[i] || toff[i]) ?
                           16'h0000 :
                           (q.age_err[i] >= WIN_L ? WIN_L :
                            q.age_err[i] + 16'h0001);
            d.thh[i] = q.special[i] ? q.ovr_hi[i] : q.thr_hi;
            d.thl[i] = q.special[i] ? q.ovr_lo[i] : q.thr_lo;
        end
        d.vmode = q.special;
        d.settle = valid ? q.settle : q.settle + 16'h0001;

        // Pins carry pattern and its inverse
        d.pd = u_pif.code;
        d.pdn = ~u_pif.code;
        // Delay line matches pin-to-level latency of four cycles
        d.expd = {q.expd[3:0], u_pif.code};

        d.tick = (q.pre == MS_L);
        d.pre = d.tick ? 16'h0000 : q.pre + 16'h0001;
        if (q.tick) begin
            if (q.blink_ms == BLINK_MS - 8'h01) begin
                d.blink_ms = 8'h00;
                d.blink = !q.blink;
            end else begin
                d.blink_ms = q.blink_ms + 8'h01;
            end
        end
        if (!mixed) begin
            d.mix_ms = 16'h0000;
        end else if (q.tick && q.mix_ms != 16'hFFFF) begin
            d.mix_ms = q.mix_ms + 16'h0001;
        end

        // Arm only after a full OFF
        if (valid && all_off) begin
            d.armed = 1'b1;
        end
        if (!valid) begin
            d.st = q.st;
        end else if (any_err || skew_over) begin
            d.st = SIE_ERR;
            d.armed = 1'b0;
        end else begin
            unique case (q.st)
                SIE_OFF: begin
                    if (all_on && q.armed) begin
                        d.st = SIE_ON;
                    end
                end
                SIE_ON: begin
                    if (!all_on) begin
                        d.st = SIE_OFF;
                    end
                end
                SIE_ERR: begin
                    // Only a full OFF leaves ERROR
                    if (all_off) begin
                        d.st = SIE_OFF;
                    end
                end
            endcase
        end
        d.on_o = (d.st == SIE_ON);
        d.err_o = (d.st == SIE_ERR) && d.err_en;

        d.led_g = ton;
        d.led_r = toff;
        d.led_o = terr & {N_TERM{q.blink}};

        // Read mux
        if (avs_address[7:5] == 3'h0) begin
            unique case ({avs_address[4:2], 2'b00})
                OFS_CTRL[4:0]: begin
                    rd[CTRL_ERR_EN] = q.err_en;
                    rd[CTRL_ESTOP] = q.estop;
                    rd[CTRL_SKEW_EN] = q.skew_en;
                    rd[CTRL_CNT_LSB+:4] = q.cnt;
                end
                OFS_SKEW[4:0]: rd[15:0] = q.skew_lim;
                OFS_THR[4:0]: rd[15:0] = {q.thr_lo, q.thr_hi};
                OFS_SPECIAL[4:0]: rd[7:0] = 8'(q.special);
                OFS_STATUS[4:0]: begin
                    rd[1:0] = q.st;
                    rd[2] = q.on_o;
                    rd[3] = q.err_o;
                    rd[4] = q.armed;
                    rd[5] = valid;
                    rd[15:8] = 8'(ton);
                    rd[23:16] = 8'(terr);
                    rd[31:24] = 8'(toff);
                end
                default: rd = 32'h0000_0000;
            endcase
        end else if (avs_address[7:5] == BLK_SHAPE && 32'(ix) < N_TERM) begin
            rd[7:0] = {q.sh_off[ix], q.sh_on[ix]};
        end else if (avs_address[7:5] == BLK_OVR && 32'(ix) < N_TERM) begin
            rd[15:0] = {q.ovr_lo[ix], q.ovr_hi[ix]};
        end

        // Avalon handshake: one wait cycle, answer on the second edge
        d.wreq = !((avs_read || avs_write) && q.wreq);
        if (avs_read && q.wreq) begin
            d.rdata = rd;
        end
        if (avs_write && !q.wreq) begin
            wv = merge(rd, avs_writedata, avs_byteenable);
            if (avs_address == OFS_CTRL) begin
                d.err_en = wv[CTRL_ERR_EN];
                d.estop = wv[CTRL_ESTOP];
                d.skew_en = wv[CTRL_SKEW_EN];
                d.cnt = wv[CTRL_CNT_LSB+:4];
                if (d.cnt == 4'h0 || 32'(d.cnt) > N_TERM) begin
                    d.cnt = 4'(N_TERM);
                end
            end else if (avs_address == OFS_SKEW) begin
                d.skew_lim = wv[15:0];
            end else if (avs_address == OFS_THR) begin
                d.thr_hi = wv[7:0];
                d.thr_lo = wv[15:8];
            end else if (avs_address == OFS_SPECIAL) begin
                d.special = wv[N_TERM-1:0];
            end else if (avs_address[7:5] == BLK_SHAPE &&
                         32'(ix) < N_TERM && avs_address[1:0] == 2'b00) begin
                d.sh_on[ix] = wv[3:0];
                d.sh_off[ix] = wv[7:4];
            end else if (avs_address[7:5] == BLK_OVR &&
                         32'(ix) < N_TERM && avs_address[1:0] == 2'b00) begin
                d.ovr_hi[ix] = wv[7:0];
                d.ovr_lo[ix] = wv[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= SIE_OFF;
            q.wreq <= 1'b1;
            q.skew_lim <= SKEW_RST;
            q.thr_hi <= THR_HI_RST;
            q.thr_lo <= THR_LO_RST;
            q.cnt <= TERM_CNT_RST;
            q.thh <= {N_TERM{THR_HI_RST}};
            q.thl <= {N_TERM{THR_LO_RST}};
            q.pd <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign thr_hi_code = q.thh;
    assign thr_lo_code = q.thl;
    assign thr_volt_mode = q.vmode;
    assign pulse_drive = q.pd;
    assign pulse_drive_n = q.pdn;
    assign func_on = q.on_o;
    assign func_err = q.err_o;
    assign led_red = q.led_r;
    assign led_green = q.led_g;
    assign led_orange = q.led_o;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    on_output_a: assert property (
        func_on == (q.st == SIE_ON))
        else $error("ON output disagrees with state");
    fault_output_a: assert property (
        func_err == ((q.st == SIE_ERR) && q.err_en))
        else $error("fault output disagrees with state");
    err_blocks_on_a: assert property (
        q.st == SIE_ERR |=> q.st != SIE_ON)
        else $error("ERROR went straight to ON");
    all_off_enter_a: assert property (
        valid && all_off && q.st != SIE_OFF |=> q.st == SIE_OFF)
        else $error("full OFF did not give OFF");
    all_on_enter_a: assert property (
        valid && q.st == SIE_OFF && q.armed && all_on && !any_err
        |=> q.st == SIE_ON ##0 func_on)
        else $error("full ON from OFF did not give ON");
    skew_error_a: assert property (
        skew_over |=> q.st == SIE_ERR)
        else $error("skew overrun did not give ERROR");
    term_error_a: assert property (
        any_err |=> q.st == SIE_ERR ##0 !func_on)
        else $error("terminal error did not give ERROR");
    pulse_high_a: assert property (
        q.sh_on[0] == SH_PULSE_A && q.lvl[0] && stab[0] && !q.expd[4][0]
        |=> q.age_on[0] == 16'h0000 ##1 !ton[0])
        else $error("steady high accepted as coded pulse");
    led_colour_a: assert property (
        led_green == $past(ton) && led_red == $past(toff))
        else $error("LED colour wrong");
    hysteresis_a: assert property (
        q.shi[0][2] && q.shi[0][1] |=> q.lvl[0])
        else $error("level missed high threshold");
    inverse_a: assert property (
        pulse_drive_n == ~pulse_drive)
        else $error("inverted pulse not exact inverse");
    startup_a: assert property (
        !q.armed |-> q.st != SIE_ON)
        else $error("ON without a prior OFF");

    reach_on_c: cover property (q.st == SIE_OFF ##1 q.st == SIE_ON);
    skew_err_c: cover property (skew_over ##1 q.st == SIE_ERR);
    err_to_off_c: cover property (q.st == SIE_ERR ##1 q.st == SIE_OFF);
    term_err_c: cover property (any_err && q.st == SIE_ON);
endmodule

// [common/sie_pkg.sv]
// Constants, types and register map of the safety input evaluator.
// Assumes a 20 MHz system clock; all counts derive from it.
package sie_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SLOT_US = 100;
    localparam int SLOT_CYC = (SLOT_US * (CLK_HZ / 1_000_000));
    localparam int TP_MAX_US = 50;
    localparam int TP_CYC = (TP_MAX_US * (CLK_HZ / 1_000_000));
    localparam int WIN_SLOTS = 16;
    localparam int WIN_CYC = SLOT_CYC * WIN_SLOTS;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int MAX_TERM = 8;
    localparam logic [15:0] ESTOP_SKEW_MS = 16'h01F4;
    localparam logic [7:0] BLINK_MS = 8'hFA;
    // Register byte offsets, and block numbers in address bits 7:5
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SKEW = 8'h04;
    localparam logic [7:0] OFS_THR = 8'h08;
    localparam logic [7:0] OFS_SPECIAL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [2:0] BLK_SHAPE = 3'h1;
    localparam logic [2:0] BLK_OVR = 3'h2;
    // Control fields
    localparam int CTRL_ERR_EN = 0;
    localparam int CTRL_ESTOP = 1;
    localparam int CTRL_SKEW_EN = 2;
    localparam int CTRL_CNT_LSB = 8;
    // Reset values
    localparam logic [15:0] SKEW_RST = 16'h01F4;
    localparam logic [7:0] THR_HI_RST = 8'h50;
    localparam logic [7:0] THR_LO_RST = 8'h14;
    localparam logic [3:0] TERM_CNT_RST = 4'h1;
    // Signal shape codes
    localparam logic [3:0] SH_STEADY_HIGH = 4'h0;
    localparam logic [3:0] SH_TESTED_HIGH = 4'h1;
    localparam logic [3:0] SH_STEADY_LOW = 4'h2;
    localparam logic [3:0] SH_PULSE_A = 4'h3;
    localparam logic [3:0] SH_INV_A = 4'h7;
    localparam logic [3:0] SH_INV_D = 4'hA;
    // Coded pulse patterns, one low slot each, at different places
    localparam logic [7:0] PAT_A = 8'hFE;
    localparam logic [7:0] PAT_B = 8'hFB;
    localparam logic [7:0] PAT_C = 8'hEF;
    localparam logic [7:0] PAT_D = 8'hBF;
    typedef enum logic [1:0] {SIE_OFF, SIE_ON, SIE_ERR} sie_fsm_t;
endpackage

// [common/sie_pulse_if.sv]
// Carries the current coded pulse bits from generator to evaluator.
// Both ends run on the same system clock.
`timescale 1ns/100ps
interface sie_pulse_if;
    logic [3:0] code;
    modport gen(output code);
    modport use_side(input code);
endinterface

// [rtl/sie_pulse_gen.sv]
// Coded pulse generator for the four own-unit pulse shapes.
// Assumes the evaluator delays these bits to match its input path.
`timescale 1ns/100ps
module sie_pulse_gen
    import sie_pkg::*;
#(
    parameter int SLOT = SLOT_CYC
) (
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Pulse bits
    sie_pulse_if.gen pif
);
    if (SLOT < 2 || SLOT > 65535) begin : g_bad
        $error("sie_pulse_gen: SLOT out of range");
    end

    localparam logic [15:0] SLOT_L = 16'(SLOT - 1);

    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0] slot;
        logic [3:0] code;
    } sie_gen_t;

    sie_gen_t q, d;

    always_comb begin
        d = q;
        if (q.cnt == SLOT_L) begin
            d.cnt = 16'h0000;
            d.slot = q.slot + 3'h1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
        d.code = {PAT_D[d.slot], PAT_C[d.slot], PAT_B[d.slot],
                  PAT_A[d.slot]};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.code <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign pif.code = q.code;
endmodule

// [dv/sie_field_model.sv]
// Field side model: contacts and pulse loopback wiring per terminal.
// Assumes mode changes at clock edges; levels are clean rail levels.
`timescale 1ns/100ps
module sie_field_model #(
    parameter int N = 2
) (
    // Terminal setting, 2 bits each
    input wire logic [2*N-1:0] mode,
    // Pulse wiring from the unit
    input wire logic [3:0] pulse_drive,
    input wire logic [3:0] pulse_drive_n,
    // Comparator view
    output logic [N-1:0] above_hi,
    output logic [N-1:0] above_lo
);
    logic [N-1:0] lvl;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            case (mode[2*i +: 2])
                2'h0: lvl[i] = 1'b0;
                2'h1: lvl[i] = 1'b1;
                2'h2: lvl[i] = pulse_drive[0];
                default: lvl[i] = pulse_drive_n[0];
            endcase
        end
    end
    assign above_hi = lvl;
    assign above_lo = lvl;
endmodule

// [dv/safety_input_state_evaluator_tb.sv]
// Self-checking bench for the evaluator with two terminals.
// Assumes loopback field wiring from the field model.
`timescale 1ns/100ps
module safety_input_state_evaluator_tb;
    import sie_pkg::*;
    localparam int NT = 2;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [NT-1:0] above_hi, above_lo, led_r, led_g, led_o, vmode;
    logic [8*NT-1:0] thh, thl;
    logic [2*NT-1:0] mode = 4'h0;
    logic [3:0] pd, pdn;
    logic func_on, func_err;
    logic [31:0] rd;
    int fail_count = 0;
    int checks = 0;
    int wn;
    // Short counts keep the run brief
    sie_eval #(.N_TERM(NT), .CYC_PER_MS(20), .SLOT_P(16), .WIN_P(128),
        .TP_P(4)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .term_above_hi(above_hi),
        .term_above_lo(above_lo), .thr_hi_code(thh), .thr_lo_code(thl),
        .thr_volt_mode(vmode), .pulse_drive(pd), .pulse_drive_n(pdn),
        .func_on(func_on), .func_err(func_err), .led_red(led_r),
        .led_green(led_g), .led_orange(led_o));
    sie_field_model #(.N(NT)) field_u (.mode(mode), .pulse_drive(pd),
        .pulse_drive_n(pdn), .above_hi(above_hi), .above_lo(above_lo));
    task automatic test_done();
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic readchk(input string nm, input logic [7:0] a,
                           input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Slow classification, so the wait is generous but bounded
    task automatic wait_out(input string nm, input logic on,
                            input logic er, input int lim = 2000);
        int n;
        n = 0;
        while ((func_on !== on || func_err !== er) && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        chk(nm, {30'h0, on, er}, {30'h0, func_on, func_err});
        if (n >= lim) begin
            test_done();
        end
    endtask
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        chk("on_rst", 32'h0, {30'h0, func_on, func_err});
        chk("thr_hi_rst", 32'h5050, {16'h0, thh});
        chk("thr_lo_rst", 32'h1414, {16'h0, thl});
        readchk("ctrl", OFS_CTRL, 32'h100);
        readchk("thr", OFS_THR, 32'h1450);
        readchk("skew", OFS_SKEW, 32'h1F4);
        readchk("unmapped", 8'hFC, 32'h0);
        bus(1'b1, 8'h20, 32'h20);
        bus(1'b1, 8'h24, 32'h21);
        bus(1'b1, OFS_SKEW, 32'h2);
        bus(1'b1, OFS_CTRL, 32'h205);
        bus(1'b1, 8'h44, 32'h0A14);
        bus(1'b1, OFS_SPECIAL, 32'h2);
        readchk("ovr", 8'h44, 32'hA14);
        chk("thr_hi", 32'h1450, {16'h0, thh});
        chk("thr_lo", 32'h0A14, {16'h0, thl});
        chk("vmode", 32'h2, {30'h0, vmode});
        repeat (300) @(posedge sys_clk);
        wait_out("off", 1'b0, 1'b0);
        chk("red", 32'h3, {30'h0, led_r});
        mode <= 4'h5;
        wait_out("on", 1'b1, 1'b0);
        chk("green", 32'h3, {30'h0, led_g});
        mode <= 4'h1;
        wait_out("skew_err", 1'b0, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("state", 32'h2, rd & 32'h3);
        mode <= 4'h5;
        repeat (600) @(posedge sys_clk);
        chk("err_hold", 32'h1, {30'h0, func_on, func_err});
        mode <= 4'h0;
        wait_out("err_clr", 1'b0, 1'b0);
        bus(1'b1, 8'h20, 32'h23);
        repeat (300) @(posedge sys_clk);
        mode <= 4'h6;
        wait_out("pulse_on", 1'b1, 1'b0);
        mode <= 4'h5;
        wait_out("shape_err", 1'b0, 1'b1);
        // Blink period is long, so the wait spans a full toggle
        wn = 0;
        while (led_o[0] !== 1'b1 && wn < 12000) begin
            @(posedge sys_clk);
            wn++;
        end
        chk("orange", 32'h1, {31'h0, led_o[0]});
        if (wn >= 12000) begin
            test_done();
        end
        mode <= 4'h0;
        wait_out("err_clr2", 1'b0, 1'b0);
        bus(1'b1, 8'h20, 32'h27);
        repeat (300) @(posedge sys_clk);
        mode <= 4'h7;
        wait_out("inv_on", 1'b1, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h207);
        mode <= 4'h3;
        repeat (2000) @(posedge sys_clk);
        chk("estop_hold", 32'h0, {30'h0, func_on, func_err});
        wait_out("estop_err", 1'b0, 1'b1, 12000);
        test_done();
    end
endmodule
